// ### utx_engine.sv
// usb function transmit engine with axi4-lite registers
//
// Design decisions made here: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
// What this block does
// - After reset: unenumerated state, function address zero.
// - After enumeration go idle; stay idle when no transaction runs.
// - Handle only IN tokens whose address equals the function address.
// - Hold loaded fifo data until a valid IN token, then send it.
// - Non-iso: answer a valid IN token with NAK when no packet is ready; iso sends nothing.
// - Host handshake after non-iso data raises transmit-done interrupt.
// - Transmit-done raised on ack or error; status tells them apart.
// - Iso: no handshake awaited, no transmit-done; start-of-frame paces.
// - Iso transaction status updates at frame end, not packet end.
// - At most one iso packet per frame.
// - Control bit 3 selects iso (1) or non-iso (0).
// - Non-iso only: handshake decides whether data sequence bit toggles.
// - Control bit 2 selects automatic or firmware marker/pointer handling.
// - Manual mode: advance-marker and reverse-pointer bits move them.
// - Failed iso transfers not retried; failed non-iso may repeat.
// - Start-of-frame raises the transmit preparation interrupt.
// - Non-iso end: transmit status updated from host handshake.
module utx_engine (
  input wire logic aclk, // clock, 200 MHz
  input wire logic aresetn, // synchronous reset, active low
  input wire logic [7:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [7:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  output logic irq, // level interrupt
  input wire logic token_valid, // decoded token pulse
  input wire logic [3:0] token_pid, // token pid
  input wire logic [6:0] token_addr, // token address field
  input wire logic sof_valid, // start-of-frame pulse
  input wire logic hs_valid, // received handshake pulse
  input wire logic [3:0] hs_pid, // received handshake pid
  input wire logic hs_error, // handshake packet had an error
  output logic tx_valid, // transmit byte valid
  output logic [7:0] tx_byte, // transmit byte
  output logic tx_last, // last byte of packet
  input wire logic tx_ready // serializer takes byte
);
  typedef struct packed {
    utx_pkg::utx_state_type state;
    logic [6:0] func_addr;
    logic iso_sel;
    logic auto_mode;
    logic enum_done;
    logic [6:0] pkt_len;
    logic pkt_ready;
    logic toggle;
    logic acked;
    logic tx_err;
    logic iso_sent;
    logic iso_pending;
    logic frame_used;
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [8:0] hs_cnt;
    logic [6:0] remaining;
    logic tx_valid;
    logic [7:0] tx_byte;
    logic tx_last;
    logic awready;
    logic wready;
    logic aw_got;
    logic w_got;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic irq;
  } utx_engine_state_type;

  utx_engine_state_type s;
  utx_engine_state_type n;
  utx_fifo_if fif();
  logic wr_fire;
  logic rd_fire;
  logic clr_int;
  logic done_evt;
  logic sof_evt;
  logic listening;
  logic token_ok;
  logic taken;
  utx_pkg::utx_state_type home;

  utx_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .fif(fif)
  );

  always_comb begin
    n = s;
    fif.push = 1'b0;
    fif.push_data = s.w_data[7:0];
    fif.pop = 1'b0;
    fif.advance = 1'b0;
    fif.reverse = 1'b0;
    clr_int = 1'b0;
    done_evt = 1'b0;
    sof_evt = 1'b0;
    // ========================================================
    // register bus: write channel
    if (awvalid && s.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && s.wready) begin
      n.w_got = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (s.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    wr_fire = s.aw_got && s.w_got && !s.bvalid;
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = utx_pkg::RESP_OKAY;
      case (s.aw_addr)
        utx_pkg::ADDR_FUNC_ADDR: begin
          if (s.w_strb[0]) begin
            n.func_addr = s.w_data[6:0];
          end
        end
        utx_pkg::ADDR_TX_CTRL: begin
          if (s.w_strb[0]) begin
            n.iso_sel = s.w_data[utx_pkg::TXCTL_ISO_BIT];
            n.auto_mode = s.w_data[utx_pkg::TXCTL_AUTO_BIT];
            // register bits move marker and pointer only when firmware owns them
            fif.advance = !s.auto_mode && s.w_data[utx_pkg::TXCTL_ADV_BIT];
            fif.reverse = !s.auto_mode && s.w_data[utx_pkg::TXCTL_REV_BIT];
          end
        end
        utx_pkg::ADDR_TXDATA: begin
          fif.push = s.w_strb[0];
        end
        utx_pkg::ADDR_TXCNT: begin
          if (s.w_strb[0]) begin
            n.pkt_len = s.w_data[6:0];
            n.pkt_ready = 1'b1;
          end
        end
        utx_pkg::ADDR_TXSTAT, utx_pkg::ADDR_INTSTAT: begin
        end
        utx_pkg::ADDR_INTMASK: begin
          if (s.w_strb[0]) begin
            n.int_mask = s.w_data[1:0];
          end
        end
        utx_pkg::ADDR_DEVCTL: begin
          if (s.w_strb[0]) begin
            n.enum_done = s.w_data[0];
          end
        end
        default: begin
          n.bresp = utx_pkg::RESP_SLVERR;
        end
      endcase
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready = !n.w_got && !n.bvalid;
    // ========================================================
    // register bus: read channel
    if (s.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    rd_fire = arvalid && s.arready;
    if (rd_fire) begin
      n.rvalid = 1'b1;
      n.rresp = utx_pkg::RESP_OKAY;
      n.rdata = 32'h00000000;
      case (araddr)
        utx_pkg::ADDR_FUNC_ADDR: n.rdata[6:0] = s.func_addr;
        utx_pkg::ADDR_TX_CTRL: begin
          n.rdata[utx_pkg::TXCTL_ISO_BIT] = s.iso_sel;
          n.rdata[utx_pkg::TXCTL_AUTO_BIT] = s.auto_mode;
        end
        utx_pkg::ADDR_TXDATA: n.rdata = 32'h00000000;
        utx_pkg::ADDR_TXCNT: n.rdata[7:0] = {s.pkt_ready, s.pkt_len};
        utx_pkg::ADDR_TXSTAT: begin
          n.rdata[8:0] = {fif.full, fif.empty, 3'(s.state), s.iso_sent, s.toggle,
                          s.tx_err, s.acked};
        end
        utx_pkg::ADDR_INTSTAT: begin
          n.rdata[1:0] = s.int_stat;
          clr_int = 1'b1;
        end
        utx_pkg::ADDR_INTMASK: n.rdata[1:0] = s.int_mask;
        utx_pkg::ADDR_DEVCTL: n.rdata[0] = s.enum_done;
        default: n.rresp = utx_pkg::RESP_SLVERR;
      endcase
    end
    n.arready = !n.rvalid;
    // ========================================================
    // frame pacing
    if (sof_valid) begin
      sof_evt = 1'b1;
      n.frame_used = 1'b0;
      n.iso_sent = s.iso_pending;
      n.iso_pending = 1'b0;
    end
    // ========================================================
    // transaction sequencer
    home = s.enum_done ? utx_pkg::UTX_IDLE : utx_pkg::UTX_UNENUM;
    listening = (s.state == utx_pkg::UTX_UNENUM) || (s.state == utx_pkg::UTX_IDLE);
    token_ok = token_valid && (token_pid == utx_pkg::PID_IN)
               && (token_addr == s.func_addr);
    taken = s.tx_valid && tx_ready;
    case (s.state)
      utx_pkg::UTX_UNENUM, utx_pkg::UTX_IDLE: begin
        if (token_ok) begin
          if (s.iso_sel) begin
            if (s.pkt_ready && !s.frame_used) begin
              n.frame_used = 1'b1;
              n.state = utx_pkg::UTX_SEND_DATA;
              n.tx_valid = 1'b1;
              n.tx_byte = utx_pkg::pid_byte(utx_pkg::PID_DATA0);
              n.tx_last = (s.pkt_len == 7'h00);
              n.remaining = s.pkt_len;
            end
          end else if (s.pkt_ready) begin
            n.state = utx_pkg::UTX_SEND_DATA;
            n.tx_valid = 1'b1;
            n.tx_byte = utx_pkg::pid_byte(s.toggle ? utx_pkg::PID_DATA1 : utx_pkg::PID_DATA0);
            n.tx_last = (s.pkt_len == 7'h00);
            n.remaining = s.pkt_len;
          end else begin
            n.state = utx_pkg::UTX_SEND_NAK;
            n.tx_valid = 1'b1;
            n.tx_byte = utx_pkg::pid_byte(utx_pkg::PID_NAK);
            n.tx_last = 1'b1;
          end
        end else begin
          n.state = home;
        end
      end
      utx_pkg::UTX_SEND_DATA: begin
        if (taken && s.tx_last) begin
          n.tx_valid = 1'b0;
          n.tx_last = 1'b0;
          if (s.iso_sel) begin
            // no handshake; packet is gone whatever happened to it
            n.pkt_ready = 1'b0;
            n.iso_pending = 1'b1;
            fif.advance = s.auto_mode;
            n.state = home;
          end else begin
            n.hs_cnt = 9'h000;
            n.state = utx_pkg::UTX_WAIT_HS;
          end
        end else if (taken) begin
          n.tx_byte = fif.rd_data;
          fif.pop = 1'b1;
          n.tx_last = (s.remaining == 7'h01);
          n.remaining = s.remaining - 7'h01;
        end
      end
      utx_pkg::UTX_SEND_NAK: begin
        if (taken) begin
          n.tx_valid = 1'b0;
          n.tx_last = 1'b0;
          n.state = home;
        end
      end
      utx_pkg::UTX_WAIT_HS: begin
        n.hs_cnt = s.hs_cnt + 9'h001;
        if (hs_valid && (hs_pid == utx_pkg::PID_ACK) && !hs_error) begin
          done_evt = 1'b1;
          n.acked = 1'b1;
          n.tx_err = 1'b0;
          n.toggle = !s.toggle;
          n.pkt_ready = 1'b0;
          fif.advance = s.auto_mode;
          n.state = home;
        end else if (hs_valid || (s.hs_cnt == 9'(utx_pkg::HS_TIMEOUT_CYC - 1))) begin
          done_evt = 1'b1;
          n.acked = 1'b0;
          n.tx_err = 1'b1;
          // packet stays ready and, in automatic mode, pointer rewinds so the host can retry
          fif.reverse = s.auto_mode;
          n.state = home;
        end
      end
      default: begin
        n.state = utx_pkg::UTX_UNENUM;
      end
    endcase
    // ========================================================
    // interrupts: a new event wins over the read clear
    n.int_stat = (clr_int ? 2'h0 : s.int_stat)
                 | {sof_evt, done_evt};
    n.irq = |(n.int_stat & n.int_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign irq = s.irq;
  assign tx_valid = s.tx_valid;
  assign tx_byte = s.tx_byte;
  assign tx_last = s.tx_last;

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence in_token_s;
    token_valid && (token_pid == utx_pkg::PID_IN) && (token_addr == s.func_addr)
      && ((s.state == utx_pkg::UTX_UNENUM) || (s.state == utx_pkg::UTX_IDLE));
  endsequence

  sequence iso_end_s;
    (s.state == utx_pkg::UTX_SEND_DATA) && s.iso_sel && tx_valid && tx_ready && tx_last;
  endsequence

  sequence hs_bad_s;
    (s.state == utx_pkg::UTX_WAIT_HS) && hs_valid
      && !((hs_pid == utx_pkg::PID_ACK) && !hs_error);
  endsequence

  reset_addr_a: assert property ($rose(aresetn) |->
    (s.func_addr == utx_pkg::FUNC_ADDR_RESET)
    && (s.state == utx_pkg::UTX_UNENUM)) else $error("reset state wrong");
  idle_enter_a: assert property ((s.state == utx_pkg::UTX_UNENUM) && s.enum_done
    && !token_valid |=> (s.state == utx_pkg::UTX_IDLE)) else $error("no idle entry");
  addr_match_a: assert property (token_valid && (token_addr != s.func_addr)
    && (s.state == utx_pkg::UTX_IDLE) |=> !tx_valid) else $error("foreign token served");
  nak_a: assert property (in_token_s and (!s.iso_sel && !s.pkt_ready)
    |=> tx_valid && tx_last && (tx_byte == utx_pkg::pid_byte(utx_pkg::PID_NAK)))
    else $error("missing nak");
  send_a: assert property (in_token_s and (!s.iso_sel && s.pkt_ready)
    |=> tx_valid && (tx_byte[3:0] == ($past(s.toggle) ? utx_pkg::PID_DATA1
    : utx_pkg::PID_DATA0))) else $error("data pid wrong");
  done_a: assert property ((s.state == utx_pkg::UTX_WAIT_HS) && hs_valid
    |=> s.int_stat[utx_pkg::INT_DONE_BIT] && (s.acked != s.tx_err))
    else $error("done not raised");
  iso_nodone_a: assert property (iso_end_s and !sof_valid |=> s.iso_pending
    && (s.state != utx_pkg::UTX_WAIT_HS) && !s.pkt_ready) else $error("iso end wrong");
  toggle_keep_a: assert property (hs_bad_s |=> (s.toggle == $past(s.toggle))
    && s.tx_err && s.pkt_ready) else $error("toggle moved");
  frame_once_a: assert property (in_token_s and (s.iso_sel && s.frame_used
    && !sof_valid) |=> !tx_valid) else $error("second iso packet");
  sof_int_a: assert property (sof_valid |=> s.int_stat[utx_pkg::INT_SOF_BIT]
    && !s.frame_used) else $error("sof not flagged");
  iso_status_a: assert property (sof_valid |=> (s.iso_sent == $past(s.iso_pending)))
    else $error("iso status not at frame end");
endmodule // utx_engine

// ### utx_engine_tb.sv
// self-checking bench of the transmit engine over its registers and link
`timescale 1ns/1ps
module utx_engine_tb;
  localparam logic [7:0] st_a = utx_pkg::ADDR_TXSTAT;
  localparam logic [7:0] is_a = utx_pkg::ADDR_INTSTAT;
  localparam logic [7:0] dat_a = utx_pkg::ADDR_TXDATA;
  localparam logic [7:0] cnt_a = utx_pkg::ADDR_TXCNT;
  localparam logic [3:0] in_p = utx_pkg::PID_IN;
  logic aclk = 1'b0;
  logic aresetn, awvalid, wvalid, bready, arvalid, rready, tx_last, tx_ready, irq;
  logic awready, wready, bvalid, arready, rvalid, token_valid, sof_valid, tx_valid;
  logic hs_valid, hs_error;
  logic [7:0] awaddr, araddr, tx_byte;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb, token_pid, hs_pid;
  logic [6:0] token_addr;
  logic [1:0] bresp, rresp, resp;
  int fail_count = 0;
  int checked = 0;
  always #2.5 aclk = ~aclk;
  utx_engine dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .irq, .token_valid, .token_pid,
    .token_addr, .sof_valid, .hs_valid, .hs_pid, .hs_error, .tx_valid,
    .tx_byte, .tx_last, .tx_ready);
  utx_host_model host (.aclk, .token_valid, .token_pid, .token_addr,
    .sof_valid, .hs_valid, .hs_pid, .hs_error, .tx_valid, .tx_byte,
    .tx_last, .tx_ready);
  // ==========
  // checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic guard(inout int n);
    n++;
    if (n > 400) begin
      fail_count++;
      give_verdict;
    end
  endtask
  // ==========
  // axi4-lite master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw, w;
    n = 0;
    {aw, w} = 2'b11;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (aw || w) begin
      @(posedge aclk);
      if (aw && awready) begin
        awvalid <= 1'b0;
        aw = 1'b0;
      end
      if (w && wready) begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
      guard(n);
    end
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!bvalid);
    resp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
      guard(n);
    end while (!rvalid);
    rd_val = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
  endtask
  // waits for a whole packet and compares it byte by byte
  task automatic chk_pkt(input logic [7:0] exp[$]);
    int n;
    n = 0;
    while (host.got.size() < exp.size()) begin
      @(posedge aclk);
      guard(n);
    end
    foreach (exp[i]) chk({24'h0, host.got[i]}, {24'h0, exp[i]});
    host.got.delete();
  endtask
  task automatic load(input logic [7:0] b);
    wr(dat_a, {24'h0, b});
    wr(cnt_a, 32'h1);
  endtask
  // ==========
  // scenarios
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    settle(2);
    aresetn <= 1'b1;
    settle(1);
    rd(utx_pkg::ADDR_FUNC_ADDR);
    chk(rd_val, 32'h0);
    rd(st_a);
    chk(rd_val & 32'h70, 32'h0);
    rd(8'h3C);
    chk({30'h0, resp}, {30'h0, utx_pkg::RESP_SLVERR});
    wr(8'h40, 32'h1);
    chk({30'h0, resp}, {30'h0, utx_pkg::RESP_SLVERR});
    host.send_token(in_p, 7'h00);
    chk_pkt({8'h5A});
    wr(utx_pkg::ADDR_FUNC_ADDR, 32'h15);
    wr(utx_pkg::ADDR_DEVCTL, 32'h1);
    rd(st_a);
    chk(rd_val & 32'h70, 32'h10);
    wr(utx_pkg::ADDR_INTMASK, 32'h3);
    wr(dat_a, 32'hA1);
    wr(dat_a, 32'hA2);
    wr(utx_pkg::ADDR_TX_CTRL, 32'h4);
    wr(cnt_a, 32'h2);
    host.send_token(in_p, 7'h16);
    settle(20);
    chk(host.got.size(), 0);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'hC3, 8'hA1, 8'hA2});
    host.send_hs(utx_pkg::PID_ACK, 1'b0);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    rd(st_a);
    chk(rd_val & 32'h87, 32'h85);
    rd(is_a);
    chk(rd_val, 32'h1);
    rd(is_a);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    host.slow = 1'b1;
    load(8'hB7);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'h4B, 8'hB7});
    host.send_hs(utx_pkg::PID_ACK, 1'b1);
    settle(2);
    chk({31'h0, irq}, 32'h1);
    wr(utx_pkg::ADDR_INTMASK, 32'h0);
    settle(1);
    chk({31'h0, irq}, 32'h0);
    wr(utx_pkg::ADDR_INTMASK, 32'h3);
    rd(st_a);
    chk(rd_val & 32'h7, 32'h6);
    rd(is_a);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'h4B, 8'hB7});
    settle(310);
    rd(st_a);
    chk(rd_val & 32'h7, 32'h6);
    rd(is_a);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'h4B, 8'hB7});
    host.send_hs(utx_pkg::PID_ACK, 1'b0);
    settle(2);
    rd(st_a);
    chk(rd_val & 32'h7, 32'h1);
    rd(is_a);
    host.slow = 1'b0;
    wr(utx_pkg::ADDR_TX_CTRL, 32'hC);
    load(8'h5E);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'hC3, 8'h5E});
    settle(20);
    rd(is_a);
    chk(rd_val, 32'h0);
    load(8'h6F);
    host.send_token(in_p, 7'h15);
    settle(20);
    chk(host.got.size(), 0);
    rd(st_a);
    chk(rd_val & 32'h8, 32'h0);
    host.send_sof();
    settle(2);
    rd(st_a);
    chk(rd_val & 32'h8, 32'h8);
    rd(is_a);
    chk(rd_val, 32'h2);
    // manual mode: the pointer only moves back on the firmware's pulse
    wr(utx_pkg::ADDR_TX_CTRL, 32'h0);
    wr(cnt_a, 32'h1);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'hC3, 8'h6F});
    host.send_hs(utx_pkg::PID_ACK, 1'b0);
    settle(2);
    rd(st_a);
    chk(rd_val & 32'h80, 32'h80);
    wr(utx_pkg::ADDR_TX_CTRL, 32'h1);
    rd(st_a);
    chk(rd_val & 32'h80, 32'h0);
    wr(cnt_a, 32'h1);
    host.send_token(in_p, 7'h15);
    chk_pkt({8'h4B, 8'h6F});
    give_verdict;
  end
endmodule // utx_engine_tb

// ### utx_fifo.sv
// transmit fifo with read pointer and read marker
`timescale 1ns/1ps
module utx_fifo (
  input wire logic aclk, // clock
  input wire logic aresetn, // synchronous reset, active low
  utx_fifo_if.store fif // engine side
);
  typedef struct packed {
    logic [6:0] wr_ptr;
    logic [6:0] rd_ptr;
    logic [6:0] marker;
  } utx_fifo_state_type;

  utx_fifo_state_type s;
  utx_fifo_state_type n;
  logic [7:0] mem [0:utx_pkg::FIFO_DEPTH-1];

  // ==========================================================
  // flags; bytes behind the marker stay held until released
  assign fif.rd_data = mem[s.rd_ptr[utx_pkg::FIFO_AW-1:0]];
  assign fif.empty = (s.rd_ptr == s.wr_ptr);
  assign fif.full = ((s.wr_ptr - s.marker) == 7'(utx_pkg::FIFO_DEPTH));

  always_comb begin
    n = s;
    if (fif.push && !fif.full) begin
      n.wr_ptr = s.wr_ptr + 7'h01;
    end
    if (fif.pop && !fif.empty) begin
      n.rd_ptr = s.rd_ptr + 7'h01;
    end
    if (fif.advance) begin
      n.marker = s.rd_ptr;
    end
    if (fif.reverse) begin
      n.rd_ptr = s.marker;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  always_ff @(posedge aclk) begin
    if (fif.push && !fif.full) begin
      mem[s.wr_ptr[utx_pkg::FIFO_AW-1:0]] <= fif.push_data;
    end
  end
endmodule // utx_fifo

// ### utx_fifo_if.sv
// carrier between the transmit engine and its fifo
`timescale 1ns/1ps
interface utx_fifo_if;
  logic push;
  logic [7:0] push_data;
  logic pop;
  logic advance;
  logic reverse;
  logic [7:0] rd_data;
  logic empty;
  logic full;
  modport engine(output push, output push_data, output pop, output advance,
                 output reverse, input rd_data, input empty, input full);
  modport store(input push, input push_data, input pop, input advance,
                input reverse, output rd_data, output empty, output full);
endinterface

// ### utx_host_model.sv
// host-side model: tokens, frame marks, handshakes, byte sink
`timescale 1ns/1ps
module utx_host_model (
  input wire logic aclk, // clock
  output logic token_valid, // token pulse
  output logic [3:0] token_pid, // token pid
  output logic [6:0] token_addr, // token address
  output logic sof_valid, // frame pulse
  output logic hs_valid, // handshake pulse
  output logic [3:0] hs_pid, // handshake pid
  output logic hs_error, // damaged handshake
  input wire logic tx_valid, // byte valid
  input wire logic [7:0] tx_byte, // byte
  input wire logic tx_last, // last byte
  output logic tx_ready // byte taken
);
  logic [7:0] got[$];
  logic slow;
  initial begin
    {token_valid, sof_valid, hs_valid, hs_error, slow} = 5'h00;
    token_pid = 4'h0;
    token_addr = 7'h00;
    hs_pid = 4'h0;
    tx_ready = 1'b1;
  end
  // ==========
  // byte sink, stalls every other cycle when slow
  always @(posedge aclk) begin
    if (tx_valid && tx_ready) got.push_back(tx_byte);
    tx_ready <= slow ? ~tx_ready : 1'b1;
  end
  // ==========
  // one-cycle pulses; idle lines carry inverted values
  task automatic send_token(input logic [3:0] pid, input logic [6:0] a);
    token_pid <= pid;
    token_addr <= a;
    token_valid <= 1'b1;
    @(posedge aclk);
    token_valid <= 1'b0;
    token_pid <= ~pid;
    token_addr <= ~a;
  endtask
  task automatic send_sof;
    sof_valid <= 1'b1;
    @(posedge aclk);
    sof_valid <= 1'b0;
  endtask
  task automatic send_hs(input logic [3:0] pid, input logic err);
    hs_pid <= pid;
    hs_error <= err;
    hs_valid <= 1'b1;
    @(posedge aclk);
    hs_valid <= 1'b0;
    hs_pid <= ~pid;
    hs_error <= ~err;
  endtask
endmodule // utx_host_model

// ### utx_pkg.sv
// shared constants and types of the usb function transmit engine
package utx_pkg;
  // ==========================================================
  // register map (byte addresses, one aligned word each)
  localparam logic [7:0] ADDR_FUNC_ADDR = 8'h00;
  localparam logic [7:0] ADDR_TX_CTRL = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_TXCNT = 8'h0C;
  localparam logic [7:0] ADDR_TXSTAT = 8'h10;
  localparam logic [7:0] ADDR_INTSTAT = 8'h14;
  localparam logic [7:0] ADDR_INTMASK = 8'h18;
  localparam logic [7:0] ADDR_DEVCTL = 8'h1C;
  // ==========================================================
  // field positions and reset values
  localparam int TXCTL_ISO_BIT = 3;
  localparam int TXCTL_AUTO_BIT = 2;
  localparam int TXCTL_ADV_BIT = 1;
  localparam int TXCTL_REV_BIT = 0;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_SOF_BIT = 1;
  localparam logic [6:0] FUNC_ADDR_RESET = 7'h00;
  // ==========================================================
  // fifo and timing
  localparam int FIFO_DEPTH = 64;
  localparam int FIFO_AW = 6;
  localparam int CLK_MHZ = 200;
  localparam int HS_TIMEOUT_NS = 1500;
  localparam int HS_TIMEOUT_CYC = (HS_TIMEOUT_NS * CLK_MHZ) / 1000;
  // ==========================================================
  // packet identifiers and bus responses
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_DATA0 = 4'h3;
  localparam logic [3:0] PID_DATA1 = 4'hB;
  localparam logic [3:0] PID_ACK = 4'h2;
  localparam logic [3:0] PID_NAK = 4'hA;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    UTX_UNENUM,
    UTX_IDLE,
    UTX_SEND_DATA,
    UTX_SEND_NAK,
    UTX_WAIT_HS
  } utx_state_type;

  // pid byte with its check nibble
  function automatic logic [7:0] pid_byte(input logic [3:0] pid);
    pid_byte = {~pid, pid};
  endfunction
endpackage
